// >>> hdl/csto_pkg.sv
// Constants for the clock strap and timer pulse output block.
// Assumes a single 25 MHz system clock and no software register bus.
package csto_pkg;

    // =========================================================
    // Clock mode encodings
    localparam logic [2:0] CSTO_MODE_RESET = 3'h0;
    localparam int CSTO_MODE_W = 3;

    // =========================================================
    // Machine clock divider
    // Divide value: machine cycle = 2 * CSTO_HALF_DIV sys_clk cycles
    localparam logic [7:0] CSTO_HALF_DIV_DEFAULT = 8'h01;
    localparam logic [7:0] CSTO_CNT_RESET = 8'h00;

    // =========================================================
    // Timer defaults
    localparam int CSTO_TMR_W = 16;
    localparam logic [15:0] CSTO_TMR_RESET = 16'h0000;

    // Output phase state of the machine clock
    typedef enum logic [1:0] {
        CSTO_PH_HIGH = 2'b01,
        CSTO_PH_LOW = 2'b10
    } csto_phase_t;

endpackage : csto_pkg

// >>> hdl/csto_timer.sv
// Down-counting timer that flags each pass below zero.
// Assumes a one-cycle tick marking each machine cycle.
`timescale 1ns/1ps
`default_nettype none
module csto_timer
    import csto_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic [CSTO_TMR_W-1:0] period,
    output logic expire
);

    logic [CSTO_TMR_W-1:0] count_reg;

    // =========================================================
    // Count down once per machine cycle, reload on passing zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= CSTO_TMR_RESET; // R12
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (tick) begin
                if (count_reg == CSTO_TMR_RESET) begin
                    count_reg <= period;
                    expire <= 1'b1;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end

endmodule : csto_timer
`default_nettype wire

// >>> hdl/csto_top.sv
// Clock strap capture, machine clock output and timer pulse outputs.
// Assumes sys_clk stands for the selected clock source (oscillator or the
// external clock on osc_in_ext_clock); pins are two-signal tristates (value and enable).
// Straps must stand steady while rstn is low; mode_wr is dropped on the
// first edge after release, when the straps are caught once more.
//
// Notes on behaviour
// R1: Machine clock output runs one full period per machine cycle, rising edges bound it.
// R2: Machine clock output floats while output-float input is low.
// R3: Straps are latched during reset into the clock mode register.
// R4: Software may rewrite clock mode; straps ignored until next reset.
// R5: An external clock on the oscillator input serves as the clock.
// R6: Timer A pulse is one machine clock cycle wide on each expiry.
// R7: Timer B pulses each time it counts down past zero.
// R8: Timer B pulse lasts exactly one machine clock cycle.
// R9: Timer B pulse reaches shared pin only while host port disabled.
// R10: Timer A output floats while output-float input is low.
// R11: Timer B shared pin floats while output-float input is low.
// R12: Reset stops and reinitialises clock generator and both timers.
// R13: Timer pulses are high-going and change only on machine clock edges.
`timescale 1ns/1ps
`default_nettype none
module csto_top
    import csto_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic osc_in_ext_clock,
    input wire logic ext_clock_sel,
    input wire logic output_float_n,
    input wire logic clock_mode_strap_a,
    input wire logic clock_mode_strap_b,
    input wire logic clock_mode_strap_c,
    input wire logic mode_wr,
    input wire logic [CSTO_MODE_W-1:0] mode_wdata,
    input wire logic [7:0] half_div,
    input wire logic [CSTO_TMR_W-1:0] timer_a_period,
    input wire logic [CSTO_TMR_W-1:0] timer_b_period,
    input wire logic host_port_enable,
    input wire logic host_irq_in,
    output logic [CSTO_MODE_W-1:0] clock_mode,
    output logic clock_src_ext,
    output logic machine_clock_out,
    output logic machine_clock_oe,
    output logic timer_a_pulse_out,
    output logic timer_a_oe,
    output logic host_irq_out,
    output logic host_irq_oe
);

    logic strap_done_reg;
    logic [7:0] cnt_reg;
    csto_phase_t phase_reg;
    logic mc_rise;
    logic a_exp;
    logic b_exp;
    logic a_hold_reg;
    logic b_hold_reg;
    logic [7:0] div_eff;
    logic mc_wrap;
    logic b_level_reg;
    logic b_next;

    // =========================================================
    // Clock mode register: straps caught while reset is low
    // strap_done_reg lets the first edge after release catch them too,
    // and from then on the straps are ignored until the next reset.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || !strap_done_reg) begin
            clock_mode <= {clock_mode_strap_c, clock_mode_strap_b,
                clock_mode_strap_a}; // R3
        end else if (mode_wr) begin
            clock_mode <= mode_wdata; // R4
        end
    end

    // =========================================================
    // Source select status: external clock on the oscillator pin
    // sys_clk already stands for whichever source the board selected.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clock_src_ext <= 1'b0;
        end else begin
            clock_src_ext <= ext_clock_sel; // R5
        end
    end

    // =========================================================
    // Machine clock generator
    // A half_div of zero counts as one; the >= compare would wrap every sys_clk anyway
    assign div_eff = (half_div == CSTO_CNT_RESET) ?
        CSTO_HALF_DIV_DEFAULT : half_div;

    // Last sys_clk of a half machine cycle; a new half_div takes effect
    // within the half cycle under way
    assign mc_wrap = (cnt_reg + 8'h01) >= div_eff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= CSTO_CNT_RESET; // R12
            phase_reg <= CSTO_PH_LOW;
        end else if (mc_wrap) begin
            cnt_reg <= CSTO_CNT_RESET;
            case (phase_reg)
                CSTO_PH_HIGH: phase_reg <= CSTO_PH_LOW;
                CSTO_PH_LOW: phase_reg <= CSTO_PH_HIGH; // R1
                default: phase_reg <= CSTO_PH_LOW;
            endcase
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // One-cycle strobe at each coming rising edge of the machine clock
    assign mc_rise = mc_wrap && (phase_reg == CSTO_PH_LOW);

    // Machine clock pin and its enable; the enable lags the float input
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            machine_clock_out <= 1'b0;
            machine_clock_oe <= 1'b0;
        end else begin
            machine_clock_out <= mc_rise ? 1'b1
                : (mc_wrap ? 1'b0 : machine_clock_out); // R1
            machine_clock_oe <= output_float_n; // R2
        end
    end

    // =========================================================
    // Timers counting machine cycles
    // Each reloads its period on passing zero, so it expires every
    // period + 1 machine cycles; both start from zero after reset.
    csto_timer u_timer_a (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(mc_rise),
        .period(timer_a_period),
        .expire(a_exp)
    );

    csto_timer u_timer_b (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(mc_rise),
        .period(timer_b_period),
        .expire(b_exp)
    );

    // =========================================================
    // Expiry pending flags
    // The timer flags an expiry one sys_clk after the tick that caused
    // it, so the flag waits here for the next machine clock rising edge,
    // where the pin pulse begins. The set wins over the clear, so an
    // expiry that lands on that edge is kept for the following one.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            a_hold_reg <= 1'b0;
        end else if (a_exp) begin
            a_hold_reg <= 1'b1; // R6
        end else if (mc_rise) begin
            a_hold_reg <= 1'b0; // R13
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            b_hold_reg <= 1'b0;
        end else if (b_exp) begin
            b_hold_reg <= 1'b1; // R7
        end else if (mc_rise) begin
            b_hold_reg <= 1'b0; // R13
        end
    end

    // =========================================================
    // Timer B pulse level
    // Renewed only at machine clock rising edges, so a pulse spans one
    // whole machine cycle whatever the divider.
    assign b_next = mc_rise ? b_hold_reg : b_level_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            b_level_reg <= 1'b0;
        end else begin
            b_level_reg <= b_next; // R8
        end
    end

    // =========================================================
    // Timer A pin: high from one machine clock rising edge to the next
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timer_a_pulse_out <= 1'b0;
            timer_a_oe <= 1'b0;
        end else begin
            if (mc_rise) begin
                timer_a_pulse_out <= a_hold_reg; // R6
            end
            timer_a_oe <= output_float_n; // R10
        end
    end

    // =========================================================
    // Shared pin: host interrupt while the host port is enabled, else
    // the timer B pulse; both follow the same float input
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            host_irq_out <= 1'b0;
            host_irq_oe <= 1'b0;
        end else begin
            host_irq_out <= host_port_enable ? host_irq_in : b_next; // R9
            host_irq_oe <= output_float_n; // R11
        end
    end

endmodule : csto_top
`default_nettype wire

// >>> sim/csto_checker.sv
// Checker for the clock strap and timer pulse output pins.
// Bound to csto_top; watches only its ports.
`timescale 1ns/1ps
`default_nettype none
module csto_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic output_float_n,
    input wire logic clock_mode_strap_a,
    input wire logic clock_mode_strap_b,
    input wire logic clock_mode_strap_c,
    input wire logic mode_wr,
    input wire logic [2:0] mode_wdata,
    input wire logic [7:0] half_div,
    input wire logic host_port_enable,
    input wire logic [2:0] clock_mode,
    input wire logic machine_clock_out,
    input wire logic machine_clock_oe,
    input wire logic timer_a_pulse_out,
    input wire logic timer_a_oe,
    input wire logic host_irq_out,
    input wire logic host_irq_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Pin float, strap capture and pulse timing
    mc_float_a: assert property ($past(rstn)
        |-> machine_clock_oe == $past(output_float_n))
        else $error("machine clock enable wrong");
    ta_float_a: assert property ($past(rstn)
        |-> timer_a_oe == $past(output_float_n))
        else $error("timer a enable wrong");
    tb_float_a: assert property ($past(rstn)
        |-> host_irq_oe == $past(output_float_n))
        else $error("shared pin enable wrong");
    mc_toggle_a: assert property ($rose(machine_clock_out) && half_div == 8'h01
        |=> $fell(machine_clock_out) ##1 $rose(machine_clock_out))
        else $error("machine clock period wrong");
    strap_latch_a: assert property ($rose(rstn) |-> clock_mode ==
        {clock_mode_strap_c, clock_mode_strap_b, clock_mode_strap_a})
        else $error("straps not captured");
    mode_write_a: assert property (mode_wr |=> clock_mode == $past(mode_wdata))
        else $error("mode write lost");
    mode_keep_a: assert property ($past(rstn) && !mode_wr |=> $stable(clock_mode))
        else $error("mode changed without write");
    ta_width_a: assert property ($rose(timer_a_pulse_out) && half_div == 8'h01
        |=> timer_a_pulse_out ##1 !timer_a_pulse_out)
        else $error("timer a pulse width wrong");
    tb_width_a: assert property ($rose(host_irq_out) && $rose(machine_clock_out)
        && !host_port_enable && !$past(host_port_enable) && half_div == 8'h01
        |=> host_irq_out ##1 !host_irq_out)
        else $error("timer b pulse width wrong");
    pulse_sync_a: assert property ($changed(timer_a_pulse_out)
        |-> $rose(machine_clock_out))
        else $error("timer a pulse off machine clock edge");
endmodule : csto_checker
bind csto_top csto_checker csto_checker_inst (.*);
`default_nettype wire

// >>> sim/csto_board.sv
// Board model: external clock source and the load on the output pins.
// A pin whose enable is low reads z on the board.
`timescale 1ns/1ps
`default_nettype none
module csto_board (
    input wire logic sys_clk,
    input wire logic mc,
    input wire logic mc_oe,
    input wire logic ta,
    input wire logic ta_oe,
    input wire logic tb,
    input wire logic tb_oe,
    output wire logic ext_clk,
    output wire logic mc_pin,
    output wire logic ta_pin,
    output wire logic tb_pin
);
    // External source follows the board oscillator
    assign ext_clk = sys_clk;
    // Each pin floats while its enable is low
    assign mc_pin = mc_oe ? mc : 1'bz;
    assign ta_pin = ta_oe ? ta : 1'bz;
    assign tb_pin = tb_oe ? tb : 1'bz;
endmodule : csto_board
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for csto_top with the board model on its pins.
// Runs half_div of 1 (two sys_clk per machine cycle), then 2 and 0 late on.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0, rstn = 1'b0, ext_clock_sel = 1'b0;
    logic output_float_n = 1'b1, mode_wr = 1'b0, host_irq_in = 1'b0;
    logic clock_mode_strap_a = 1'b1, clock_mode_strap_b = 1'b0;
    logic clock_mode_strap_c = 1'b1, host_port_enable = 1'b0;
    logic [2:0] mode_wdata = 3'h0, clock_mode;
    logic [7:0] half_div = 8'h01;
    logic [15:0] timer_a_period = 16'h0002, timer_b_period = 16'h0004;
    logic clock_src_ext, machine_clock_out, machine_clock_oe;
    logic timer_a_pulse_out, timer_a_oe, host_irq_out, host_irq_oe;
    wire osc_in_ext_clock, mc_pin, ta_pin, tb_pin;
    int miscompares = 0, comparisons = 0;
    csto_top csto_top_inst (.*);
    csto_board csto_board_inst (.sys_clk(sys_clk), .mc(machine_clock_out),
        .mc_oe(machine_clock_oe), .ta(timer_a_pulse_out), .ta_oe(timer_a_oe),
        .tb(host_irq_out), .tb_oe(host_irq_oe), .ext_clk(osc_in_ext_clock),
        .mc_pin(mc_pin), .ta_pin(ta_pin), .tb_pin(tb_pin));
    always #20 sys_clk = ~sys_clk;
    // ==========================================================
    // Compare, close and timing helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    function automatic logic pin(input bit b);
        return b ? tb_pin : ta_pin;
    endfunction : pin
    // Width, then rise-to-rise span of one timer pulse, in sys_clk cycles
    task automatic gap(input bit b, input logic [15:0] w,
        input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        while (pin(b) !== 1'b0) @(negedge sys_clk);
        while (pin(b) !== 1'b1) @(negedge sys_clk);
        while (pin(b) === 1'b1) begin n++; @(negedge sys_clk); end
        chk(n, w);
        while (pin(b) === 1'b0) begin n++; @(negedge sys_clk); end
        chk(n, exp);
    endtask : gap
    // ==========================================================
    // Scenarios
    task automatic t_mode;
        @(posedge sys_clk);
        mode_wr <= 1'b1;
        mode_wdata <= 3'h6;
        @(posedge sys_clk);
        mode_wdata <= 3'h4;
        @(posedge sys_clk);
        mode_wr <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(clock_mode, 3'h4);
    endtask : t_mode
    task automatic t_float;
        @(posedge sys_clk) output_float_n <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({mc_pin, ta_pin, tb_pin}, 3'hz);
        @(posedge sys_clk) output_float_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({machine_clock_oe, timer_a_oe, host_irq_oe}, 3'h7);
    endtask : t_float
    task automatic t_host;
        @(posedge sys_clk) host_port_enable <= 1'b1;
        host_irq_in <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(tb_pin, 1'b1);
        @(posedge sys_clk) host_irq_in <= 1'b0;
        repeat (2) @(negedge sys_clk);
        repeat (12) begin @(negedge sys_clk); chk(tb_pin, 1'b0); end
        @(posedge sys_clk) host_port_enable <= 1'b0;
    endtask : t_host
    task automatic t_ext;
        @(posedge sys_clk) ext_clock_sel <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(clock_src_ext, 1'b1);
    endtask : t_ext
    task automatic t_reset(input logic [5:0] exp);
        @(posedge sys_clk) rstn <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({clock_mode, machine_clock_out, timer_a_pulse_out,
            host_irq_out}, exp);
        @(posedge sys_clk) rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : t_reset
    initial begin
        t_reset(6'h28);
        clock_mode_strap_b <= 1'b1;
        clock_mode_strap_c <= 1'b0;
        gap(1'b0, 16'h0002, 16'h0006);
        gap(1'b1, 16'h0002, 16'h000a);
        chk(clock_mode, 3'h5);
        t_mode();
        t_float();
        t_host();
        t_ext();
        @(posedge sys_clk) half_div <= 8'h02;
        t_reset(6'h18);
        gap(1'b0, 16'h0004, 16'h000c);
        @(posedge sys_clk) half_div <= 8'h00;
        gap(1'b0, 16'h0002, 16'h0006);
        wrap_up();
    end
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
